// [hw/cpu_regs_pkg.sv]
// Constants and types for the programmer-visible register set
package cpu_regs_pkg;
   // Status flag positions
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_I = 2;
   localparam int FLAG_D = 3;
   localparam int FLAG_B = 4;
   localparam int FLAG_T = 5;
   localparam int FLAG_V = 6;
   localparam int FLAG_N = 7;
   // Reset vector and stack pages
   localparam logic [15:0] RESET_VEC_LO   = 16'hfffa;
   localparam logic [15:0] RESET_VEC_HI   = 16'hfffb;
   localparam logic [7:0]  STACK_PAGE_ONE = 8'h01;
   localparam logic [7:0]  STACK_PAGE_ZP  = 8'h00;
   localparam logic [7:0]  ZERO_PAGE      = 8'h00;
   localparam logic [7:0]  STATUS_RST     = 8'h04;
   localparam logic [7:0]  BYTE_ZERO      = 8'h00;
   localparam logic [15:0] WORD_ONE       = 16'h0001;
   // Minimum reset hold
   localparam int RST_HOLD_NS = 2000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int RST_HOLD_CYC = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register select for loads
   typedef enum logic [2:0] {
      SEL_NONE = 3'h0, SEL_ACC = 3'h1, SEL_X = 3'h3, SEL_Y = 3'h2,
      SEL_SP = 3'h6, SEL_PCL = 3'h7, SEL_PCH = 3'h5
   } reg_sel_t;

   // Flag operations
   typedef enum logic [3:0] {
      FOP_NONE = 4'h0, FOP_ARITH = 4'h1, FOP_TRANSFER = 4'h3, FOP_SHIFT = 4'h2,
      FOP_BITTEST = 4'h6, FOP_SEC = 4'h7, FOP_CLC = 4'h5, FOP_SEI = 4'h4,
      FOP_CLI = 4'hc, FOP_SED = 4'hd, FOP_CLD = 4'hf, FOP_SET = 4'he,
      FOP_CLT = 4'ha, FOP_CLV = 4'hb, FOP_PULL = 4'h9
   } flag_op_t;

   // Address modes
   typedef enum logic [2:0] {
      AM_ABS = 3'h0, AM_ABS_X = 3'h1, AM_ABS_Y = 3'h3, AM_IND_X = 3'h2,
      AM_IND_Y = 3'h6, AM_TMODE = 3'h7
   } addr_mode_t;

   // Reset fetch sequence
   typedef enum logic [1:0] {
      RS_FETCH_LO = 2'b00, RS_FETCH_HI = 2'b01, RS_RUN = 2'b11
   } rst_state_t;
endpackage : cpu_regs_pkg

// [hw/cpu_registers_and_status_flags.sv]
// Register set, status flags, address and stack formation of the CPU core
`timescale 1ns/10ps
`default_nettype none
module cpu_registers_and_status_flags
   import cpu_regs_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        srst,
   input  wire logic        stack_page_sel,
   input  wire logic        vec_valid,
   input  wire logic [7:0]  vec_data,
   input  wire reg_sel_t    load_sel,
   input  wire logic [7:0]  load_data,
   input  wire logic        pc_load,
   input  wire logic [15:0] pc_load_value,
   input  wire logic        pc_incr,
   input  wire logic        push,
   input  wire logic        pop,
   input  wire logic        int_entry,
   input  wire logic        call_entry,
   input  wire logic        brk_entry,
   input  wire flag_op_t    flag_op,
   input  wire logic [7:0]  flag_result,
   input  wire logic        flag_carry,
   input  wire logic        flag_ovf,
   input  wire logic [7:0]  flag_status_in,
   input  wire logic        irq_req,
   input  wire logic        irq_enable,
   input  wire logic        nmi_req,
   input  wire addr_mode_t  addr_mode,
   input  wire logic [15:0] operand,
   input  wire logic [15:0] pointer_data,
   output logic             reset_busy,
   output logic [15:0]      vec_addr,
   output logic [7:0]       acc,
   output logic [7:0]       index_x,
   output logic [7:0]       index_y,
   output logic [7:0]       stack_ptr,
   output logic [7:0]       processor_status,
   output logic [7:0]       instruction_pointer_high,
   output logic [7:0]       instruction_pointer_low,
   output logic [15:0]      stack_addr,
   output logic [15:0]      push_ret_addr,
   output logic [7:0]       push_status,
   output logic [15:0]      pointer_addr,
   output logic [15:0]      eff_addr,
   output logic [15:0]      tmode_dest_addr,
   output logic             use_mem_for_acc,
   output logic             decimal_arith,
   output logic             irq_accept,
   output logic             brk_accept,
   output logic             nmi_accept
);

   //----------------------------------------
   // Storage
   //----------------------------------------
   logic [7:0]  acc_ff, x_ff, y_ff, sp_ff, ps_ff;
   logic [15:0] pc_ff;
   rst_state_t  rs_ff;

   //----------------------------------------
   // Reset vector fetch
   //----------------------------------------
   // Walk the two vector bytes after reset
   always_ff @(posedge clock) begin
      if (srst) begin
         rs_ff <= RS_FETCH_LO;
      end else if (vec_valid) begin
         case (rs_ff)
            RS_FETCH_LO: rs_ff <= RS_FETCH_HI;
            RS_FETCH_HI: rs_ff <= RS_RUN;
            RS_RUN:      rs_ff <= RS_RUN;
            default:     rs_ff <= RS_FETCH_LO;
         endcase
      end
   end

   assign reset_busy = (rs_ff != RS_RUN);
   assign vec_addr   = (rs_ff == RS_FETCH_HI) ? RESET_VEC_HI : RESET_VEC_LO;

   //----------------------------------------
   // Data registers
   //----------------------------------------
   // Accumulator and index registers, eight bits each
   always_ff @(posedge clock) begin
      if (srst) begin
         acc_ff <= BYTE_ZERO;
         x_ff   <= BYTE_ZERO;
         y_ff   <= BYTE_ZERO;
      end else begin
         if (load_sel == SEL_ACC) acc_ff <= load_data;
         if (load_sel == SEL_X)   x_ff   <= load_data;
         if (load_sel == SEL_Y)   y_ff   <= load_data;
      end
   end

   // Stack pointer; software sets the base, push goes down
   always_ff @(posedge clock) begin
      if (srst) begin
         sp_ff <= BYTE_ZERO;
      end else if (load_sel == SEL_SP) begin
         sp_ff <= load_data;
      end else if (push && !pop) begin
         sp_ff <= sp_ff - 8'h01;
      end else if (pop && !push) begin
         sp_ff <= sp_ff + 8'h01;
      end
   end

   // Program counter with separately loadable halves
   always_ff @(posedge clock) begin
      if (srst) begin
         pc_ff <= 16'h0000;
      end else if (rs_ff == RS_FETCH_LO && vec_valid) begin
         pc_ff[7:0] <= vec_data;
      end else if (rs_ff == RS_FETCH_HI && vec_valid) begin
         pc_ff[15:8] <= vec_data;
      end else if (pc_load) begin
         pc_ff <= pc_load_value;
      end else if (load_sel == SEL_PCL) begin
         pc_ff[7:0] <= load_data;
      end else if (load_sel == SEL_PCH) begin
         pc_ff[15:8] <= load_data;
      end else if (pc_incr) begin
         pc_ff <= pc_ff + WORD_ONE;
      end
   end

   //----------------------------------------
   // Status flags
   //----------------------------------------
   // Flag updates by operation class; break never held live
   always_ff @(posedge clock) begin
      if (srst) begin
         ps_ff <= STATUS_RST;
      end else begin
         case (flag_op)
            FOP_ARITH: begin
               ps_ff[FLAG_Z] <= (flag_result == BYTE_ZERO);
               ps_ff[FLAG_N] <= flag_result[7];
               ps_ff[FLAG_C] <= flag_carry;
               if (!ps_ff[FLAG_D]) ps_ff[FLAG_V] <= flag_ovf;
            end
            FOP_TRANSFER: begin
               ps_ff[FLAG_Z] <= (flag_result == BYTE_ZERO);
               ps_ff[FLAG_N] <= flag_result[7];
            end
            FOP_SHIFT: begin
               ps_ff[FLAG_Z] <= (flag_result == BYTE_ZERO);
               ps_ff[FLAG_N] <= flag_result[7];
               ps_ff[FLAG_C] <= flag_carry;
            end
            FOP_BITTEST: begin
               ps_ff[FLAG_V] <= flag_status_in[6];
               ps_ff[FLAG_N] <= flag_status_in[7];
               ps_ff[FLAG_Z] <= (flag_result == BYTE_ZERO);
            end
            FOP_SEC:  ps_ff[FLAG_C] <= 1'b1;
            FOP_CLC:  ps_ff[FLAG_C] <= 1'b0;
            FOP_SEI:  ps_ff[FLAG_I] <= 1'b1;
            FOP_CLI:  ps_ff[FLAG_I] <= 1'b0;
            FOP_SED:  ps_ff[FLAG_D] <= 1'b1;
            FOP_CLD:  ps_ff[FLAG_D] <= 1'b0;
            FOP_SET:  ps_ff[FLAG_T] <= 1'b1;
            FOP_CLT:  ps_ff[FLAG_T] <= 1'b0;
            FOP_CLV:  ps_ff[FLAG_V] <= 1'b0;
            FOP_PULL: ps_ff <= flag_status_in;
            default:  ps_ff <= ps_ff;
         endcase
         if (int_entry || brk_entry) ps_ff[FLAG_I] <= 1'b1;
         ps_ff[FLAG_B] <= 1'b0;
      end
   end

   //----------------------------------------
   // Addressing
   //----------------------------------------
   // Effective address and zero-page pointer formation
   always_comb begin
      pointer_addr = {ZERO_PAGE, operand[7:0] + x_ff};
      case (addr_mode)
         AM_ABS:   eff_addr = operand;
         AM_ABS_X: eff_addr = operand + {BYTE_ZERO, x_ff};
         AM_ABS_Y: eff_addr = operand + {BYTE_ZERO, y_ff};
         AM_IND_X: eff_addr = pointer_data;
         AM_IND_Y: begin
            pointer_addr = {ZERO_PAGE, operand[7:0]};
            eff_addr     = pointer_data + {BYTE_ZERO, y_ff};
         end
         AM_TMODE: eff_addr = {ZERO_PAGE, x_ff};
         default:  eff_addr = operand;
      endcase
   end

   // Memory-to-memory mode replaces the accumulator
   assign use_mem_for_acc = ps_ff[FLAG_T];
   assign tmode_dest_addr = {ZERO_PAGE, x_ff};
   assign decimal_arith   = ps_ff[FLAG_D];

   //----------------------------------------
   // Stack and interrupts
   //----------------------------------------
   assign stack_addr    = {(stack_page_sel ? STACK_PAGE_ONE : STACK_PAGE_ZP), sp_ff};
   assign push_ret_addr = call_entry ? (pc_ff - WORD_ONE) : pc_ff;
   assign push_status   = brk_entry ? (ps_ff | 8'h10) : ps_ff;
   assign irq_accept    = irq_req && irq_enable && !ps_ff[FLAG_I] && !reset_busy;
   assign brk_accept    = brk_entry && !reset_busy;
   assign nmi_accept    = nmi_req && !reset_busy;

   assign acc                      = acc_ff;
   assign index_x                  = x_ff;
   assign index_y                  = y_ff;
   assign stack_ptr                = sp_ff;
   assign processor_status         = ps_ff;
   assign instruction_pointer_high = pc_ff[15:8];
   assign instruction_pointer_low  = pc_ff[7:0];

   //----------------------------------------
   // Checks
   //----------------------------------------
   a_reset_sets_i: assert property (@(posedge clock) srst |=> ps_ff[FLAG_I])
      else $error("I flag not set after reset");
   a_break_never_live: assert property (@(posedge clock) disable iff (srst)
      !ps_ff[FLAG_B])
      else $error("Break flag held live");
   a_push_decrements: assert property (@(posedge clock) disable iff (srst)
      push && !pop && load_sel != SEL_SP |=> sp_ff == $past(sp_ff) - 8'h01)
      else $error("Push did not decrement stack pointer");
   a_pop_increments: assert property (@(posedge clock) disable iff (srst)
      pop && !push && load_sel != SEL_SP |=> sp_ff == $past(sp_ff) + 8'h01)
      else $error("Pop did not increment stack pointer");
   a_irq_masked: assert property (@(posedge clock) disable iff (srst)
      ps_ff[FLAG_I] |-> !irq_accept)
      else $error("Interrupt accepted while masked");
   a_int_sets_i: assert property (@(posedge clock) disable iff (srst)
      int_entry |=> ps_ff[FLAG_I])
      else $error("Interrupt entry left I clear");
   a_zero_flag: assert property (@(posedge clock) disable iff (srst)
      flag_op == FOP_TRANSFER |=> ps_ff[FLAG_Z] == ($past(flag_result) == BYTE_ZERO))
      else $error("Zero flag wrong");
   a_carry_clear: assert property (@(posedge clock) disable iff (srst)
      flag_op == FOP_CLC |=> !ps_ff[FLAG_C])
      else $error("Carry not cleared");
   a_bit_test: assert property (@(posedge clock) disable iff (srst)
      flag_op == FOP_BITTEST |=> ps_ff[7:6] == $past(flag_status_in[7:6]))
      else $error("Bit test flags wrong");
   a_stack_page: assert property (@(posedge clock)
      stack_addr[15:8] == (stack_page_sel ? STACK_PAGE_ONE : STACK_PAGE_ZP))
      else $error("Stack page wrong");
   a_call_ret: assert property (@(posedge clock)
      call_entry |-> push_ret_addr == pc_ff - WORD_ONE)
      else $error("Call return address wrong");

endmodule : cpu_registers_and_status_flags
`default_nettype wire

// [tb/vector_source.sv]
// Far-side model that hands the reset vector bytes to the register set
`timescale 1ns/10ps
`default_nettype none
module vector_source
   import cpu_regs_pkg::*;
#(
   parameter logic [7:0] VEC_LO_BYTE = 8'h34,
   parameter logic [7:0] VEC_HI_BYTE = 8'h12
)(
   input  wire logic        srst,
   input  wire logic        reset_busy,
   input  wire logic [15:0] vec_addr,
   output logic             vec_valid,
   output logic [7:0]       vec_data
);
   // Answer the addressed vector byte; an idle bus shows the inverted byte
   always_comb begin
      vec_valid = reset_busy && !srst;
      vec_data = (vec_addr == RESET_VEC_HI) ? VEC_HI_BYTE : VEC_LO_BYTE;
      if (!vec_valid) begin
         vec_data = ~vec_data;
      end
   end
endmodule : vector_source
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the register set and status flags
`timescale 1ns/10ps
`default_nettype none
module tb
   import cpu_regs_pkg::*;
;
   logic clock, srst, stack_page_sel, pc_load, pc_incr, push, pop, int_entry;
   logic call_entry, brk_entry, flag_carry, flag_ovf, irq_req, irq_enable, nmi_req;
   logic [7:0] load_data, flag_result, flag_status_in;
   logic [15:0] pc_load_value, operand, pointer_data;
   reg_sel_t load_sel;
   flag_op_t flag_op;
   addr_mode_t addr_mode;
   wire logic vec_valid, reset_busy, use_mem_for_acc, decimal_arith;
   wire logic irq_accept, brk_accept, nmi_accept;
   wire logic [7:0] vec_data, acc, index_x, index_y, stack_ptr, processor_status, push_status;
   wire logic [7:0] instruction_pointer_high, instruction_pointer_low;
   wire logic [15:0] vec_addr, stack_addr, push_ret_addr, pointer_addr, eff_addr;
   wire logic [15:0] tmode_dest_addr;
   int bad_count, comparisons;

   // ----------------------------------------
   // Design, far-side model and clock
   // ----------------------------------------
   cpu_registers_and_status_flags u_cpu_registers_and_status_flags (
      .clock, .srst, .stack_page_sel, .vec_valid, .vec_data, .load_sel, .load_data,
      .pc_load, .pc_load_value, .pc_incr, .push, .pop, .int_entry, .call_entry, .brk_entry,
      .flag_op, .flag_result, .flag_carry, .flag_ovf, .flag_status_in, .irq_req,
      .irq_enable, .nmi_req, .addr_mode, .operand, .pointer_data, .reset_busy, .vec_addr,
      .acc, .index_x, .index_y, .stack_ptr, .processor_status, .instruction_pointer_high,
      .instruction_pointer_low, .stack_addr, .push_ret_addr, .push_status, .pointer_addr,
      .eff_addr, .tmode_dest_addr, .use_mem_for_acc, .decimal_arith, .irq_accept,
      .brk_accept, .nmi_accept);
   vector_source #(.VEC_LO_BYTE(8'h34), .VEC_HI_BYTE(8'h12)) u_vector_source (
      .srst, .reset_busy, .vec_addr, .vec_valid, .vec_data);
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   // One-cycle register load
   task automatic ld(input reg_sel_t s, input logic [7:0] d);
      @(posedge clock);
      load_sel <= s;
      load_data <= d;
      @(posedge clock);
      load_sel <= SEL_NONE;
   endtask : ld
   // One-cycle flag operation, then check the masked status byte
   task automatic fl(input flag_op_t f, input logic [7:0] r, input logic c, input logic v,
                     input logic [7:0] mask, input logic [7:0] want);
      @(posedge clock);
      flag_op <= f;
      flag_result <= r;
      flag_status_in <= r;
      flag_carry <= c;
      flag_ovf <= v;
      @(posedge clock);
      flag_op <= FOP_NONE;
      @(negedge clock);
      chk(processor_status & mask, want, "status flags");
   endtask : fl

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      int n;
      n = 0;
      @(negedge clock);
      chk(vec_addr, 16'hfffa, "vector low address");
      chk(reset_busy, 1'b1, "busy during fetch");
      @(negedge clock);
      chk(vec_addr, 16'hfffb, "vector high address");
      while (reset_busy !== 1'b0 && n < 10) begin
         @(negedge clock);
         n++;
      end
      if (n == 10) begin
         bad_count++;
         finish_test();
      end
      chk({instruction_pointer_high, instruction_pointer_low}, 16'h1234, "vector");
      chk(processor_status[FLAG_I], 1'b1, "I after reset");
      $display("test reset done");
   endtask : t_reset
   task automatic t_regs;
      ld(SEL_ACC, 8'ha5);
      ld(SEL_X, 8'h20);
      ld(SEL_Y, 8'hff);
      ld(SEL_SP, 8'h00);
      ld(SEL_PCL, 8'h9c);
      ld(SEL_PCH, 8'h7e);
      @(negedge clock);
      chk({acc, index_x}, 16'ha520, "acc and x");
      chk({index_y, stack_ptr}, 16'hff00, "y and sp");
      chk({instruction_pointer_high, instruction_pointer_low}, 16'h7e9c, "pc");
      $display("test regs done");
   endtask : t_regs
   task automatic t_addr;
      @(posedge clock);
      operand <= 16'h12f0;
      pointer_data <= 16'h4080;
      addr_mode <= AM_ABS_X;
      @(negedge clock);
      chk(eff_addr, 16'h1310, "abs x");
      @(posedge clock);
      addr_mode <= AM_ABS_Y;
      @(negedge clock);
      chk(eff_addr, 16'h13ef, "abs y");
      @(posedge clock);
      addr_mode <= AM_IND_X;
      @(negedge clock);
      chk(pointer_addr, 16'h0010, "ind x ptr");
      chk(eff_addr, 16'h4080, "ind x ea");
      @(posedge clock);
      addr_mode <= AM_IND_Y;
      @(negedge clock);
      chk(pointer_addr, 16'h00f0, "ind y ptr");
      chk(eff_addr, 16'h417f, "ind y ea");
      @(posedge clock);
      addr_mode <= AM_TMODE;
      @(negedge clock);
      chk(tmode_dest_addr, 16'h0020, "t dest");
      chk(eff_addr, 16'h0020, "t operand");
      @(posedge clock);
      addr_mode <= AM_ABS;
      @(negedge clock);
      chk(eff_addr, 16'h12f0, "abs plain");
      $display("test addr done");
   endtask : t_addr
   task automatic t_stack;
      @(posedge clock);
      stack_page_sel <= 1'b1;
      push <= 1'b1;
      @(posedge clock);
      push <= 1'b0;
      @(negedge clock);
      chk(stack_addr, 16'h01ff, "push page one");
      @(posedge clock);
      stack_page_sel <= 1'b0;
      push <= 1'b1;
      pop <= 1'b1;
      @(posedge clock);
      push <= 1'b0;
      @(negedge clock);
      chk(stack_addr, 16'h00ff, "push pop zero page");
      @(posedge clock);
      pop <= 1'b0;
      @(negedge clock);
      chk(stack_addr, 16'h0000, "pop");
      $display("test stack done");
   endtask : t_stack
   task automatic t_ret;
      @(posedge clock);
      pc_load <= 1'b1;
      pc_load_value <= 16'h3000;
      call_entry <= 1'b1;
      @(posedge clock);
      pc_load <= 1'b0;
      pc_incr <= 1'b1;
      @(negedge clock);
      chk(push_ret_addr, 16'h2fff, "call return");
      @(posedge clock);
      pc_incr <= 1'b0;
      call_entry <= 1'b0;
      @(negedge clock);
      chk(push_ret_addr, 16'h3001, "interrupt return");
      $display("test return done");
   endtask : t_ret
   task automatic t_irq;
      fl(FOP_CLI, 8'h00, 1'b0, 1'b0, 8'h04, 8'h00);
      @(posedge clock);
      irq_req <= 1'b1;
      irq_enable <= 1'b1;
      nmi_req <= 1'b1;
      @(negedge clock);
      chk(irq_accept, 1'b1, "irq taken");
      @(posedge clock);
      irq_enable <= 1'b0;
      @(negedge clock);
      chk(irq_accept, 1'b0, "irq disabled");
      @(posedge clock);
      irq_enable <= 1'b1;
      int_entry <= 1'b1;
      @(posedge clock);
      int_entry <= 1'b0;
      @(negedge clock);
      chk(processor_status[FLAG_I], 1'b1, "I on entry");
      chk(irq_accept, 1'b0, "irq masked");
      chk(nmi_accept, 1'b1, "nmi passes");
      @(posedge clock);
      brk_entry <= 1'b1;
      @(negedge clock);
      chk(brk_accept, 1'b1, "break passes");
      chk(push_status[FLAG_B], 1'b1, "pushed B");
      @(posedge clock);
      brk_entry <= 1'b0;
      irq_req <= 1'b0;
      nmi_req <= 1'b0;
      @(negedge clock);
      chk(processor_status[FLAG_B], 1'b0, "live B");
      fl(FOP_SEI, 8'h00, 1'b0, 1'b0, 8'h04, 8'h04);
      $display("test irq done");
   endtask : t_irq
   task automatic t_flags;
      fl(FOP_ARITH, 8'h00, 1'b1, 1'b1, 8'hc3, 8'h43);
      fl(FOP_ARITH, 8'h80, 1'b0, 1'b0, 8'hc3, 8'h80);
      fl(FOP_TRANSFER, 8'h00, 1'b0, 1'b0, 8'h82, 8'h02);
      fl(FOP_SHIFT, 8'h01, 1'b1, 1'b0, 8'h01, 8'h01);
      fl(FOP_CLC, 8'h00, 1'b0, 1'b0, 8'h01, 8'h00);
      fl(FOP_SEC, 8'h00, 1'b0, 1'b0, 8'h01, 8'h01);
      fl(FOP_BITTEST, 8'hc0, 1'b0, 1'b0, 8'hc0, 8'hc0);
      fl(FOP_CLV, 8'h00, 1'b0, 1'b0, 8'h40, 8'h00);
      fl(FOP_SED, 8'h00, 1'b0, 1'b0, 8'h08, 8'h08);
      chk(decimal_arith, 1'b1, "decimal on");
      fl(FOP_CLD, 8'h00, 1'b0, 1'b0, 8'h08, 8'h00);
      fl(FOP_SET, 8'h00, 1'b0, 1'b0, 8'h20, 8'h20);
      chk(use_mem_for_acc, 1'b1, "t mode on");
      fl(FOP_CLT, 8'h00, 1'b0, 1'b0, 8'h20, 8'h00);
      fl(FOP_PULL, 8'hff, 1'b0, 1'b0, 8'h10, 8'h00);
      $display("test flags done");
   endtask : t_flags

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      {srst, stack_page_sel, pc_load, pc_incr, push, pop, int_entry, call_entry} = 8'hff;
      {pc_load, pc_incr, push, pop, int_entry, call_entry} = 6'h00;
      {brk_entry, flag_carry, flag_ovf, irq_req, irq_enable, nmi_req} = 6'h00;
      {load_data, flag_result, flag_status_in} = 24'h000000;
      {pc_load_value, operand, pointer_data} = 48'h0;
      load_sel = SEL_NONE;
      flag_op = FOP_NONE;
      addr_mode = AM_ABS;
      bad_count = 0;
      comparisons = 0;
      repeat (RST_HOLD_CYC) @(posedge clock);
      srst <= 1'b0;
      t_reset();
      t_regs();
      t_addr();
      t_stack();
      t_ret();
      t_irq();
      t_flags();
      finish_test();
   end
endmodule : tb
`default_nettype wire
